/* hw/cos_defines.svh */
// constants for the network slave supervision block
// assumes a 200 MHz ref_clk and a plain register port
//
// Contract
// - with interlock gate on, interlock only in network state operational, code 5
// - node identifier 0..127 fills low seven bits of every 11-bit frame id
// - bit rate select: -3=20, -2=50, -1=100, 0=125, 1=250, 2=500 kbit/s
// - heartbeat sent each period, 16..200 ms, raw count 4..50 in 4 ms units
// - after slave pdo sent, reply timer runs; expiry without master pdo raises fault
// - either first or second master pdo stops timer and counts as reply
// - reply period of 0 disables the reply timeout check entirely
// - at least emergency spacing, 16..200 ms, between successive emergency messages; code counts 4 ms ticks from load, so spacing can be one tick short
// - hold flag set at power-on skips stack init until cleared and start invoked
`ifndef COS_DEFINES_SVH
`define COS_DEFINES_SVH

`define COS_CLK_MHZ 200
`define COS_TICK_MS 4
`define COS_TICK_CYC (`COS_TICK_MS * 1000 * `COS_CLK_MHZ)

`define COS_ADDR_CTRL 8'h00
`define COS_ADDR_NODE 8'h04
`define COS_ADDR_RATE 8'h08
`define COS_ADDR_HBEAT 8'h0C
`define COS_ADDR_REPLY 8'h10
`define COS_ADDR_EMCY 8'h14
`define COS_ADDR_NMT 8'h18
`define COS_ADDR_STAT 8'h1C
`define COS_ADDR_IRQ 8'h20
`define COS_ADDR_MASK 8'h24
`define COS_ADDR_START 8'h28

`define COS_CTRL_GATE 0
`define COS_CTRL_HOLD 1
`define COS_NMT_OPERATIONAL 7'h05

`define COS_EV_HBEAT 0
`define COS_EV_TMO 1
`define COS_EV_EMCY 2
`define COS_EV_INIT 3
`define COS_NEV 4

`define COS_HBEAT_RST 8'h0A
`define COS_REPLY_RST 8'h00
`define COS_EMCY_RST 8'h04

`endif

/* hw/cos_pkg.sv */
// types for the network slave supervision block
// assumes cos_defines.svh is compiled alongside
package cos_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } cos_bus_req_t;

    typedef struct packed {
        logic pdo_sent;
        logic pdo1_rcvd;
        logic pdo2_rcvd;
        logic emcy_req;
    } cos_link_ev_t;

    typedef enum logic [1:0] {
        COS_ST_HELD,
        COS_ST_INIT,
        COS_ST_RUN
    } cos_stack_t;
endpackage : cos_pkg

/* hw/cos_period_timer.sv */
// down counter of 4 ms ticks, reloadable
// assumes tick is a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
module cos_period_timer #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic load,
    input wire logic stop,
    input wire logic [W-1:0] period,
    output logic running,
    output logic expire
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
            running <= 1'b0;
        end else if (stop) begin
            running <= 1'b0;
        end else if (load) begin
            cnt_reg <= period;
            running <= (period != '0);
        end else if (running && tick) begin
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
                running <= 1'b0;
            end
        end
    end

    assign expire = running && tick && (cnt_reg <= {{(W-1){1'b0}}, 1'b1});
endmodule : cos_period_timer
`default_nettype wire

/* hw/cos_supervisor.sv */
// network slave supervision: ids, bit rate, heartbeat, reply timeout,
// emergency spacing, interlock gating, deferred stack start
// assumes synchronous inputs and a single-cycle register port
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cos_defines.svh"
module cos_supervisor #(
    parameter int TICK_CYC = `COS_TICK_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire cos_pkg::cos_bus_req_t bus_req,
    output logic [31:0] rdata,
    input wire cos_pkg::cos_link_ev_t link_ev,
    input wire logic interlock_request,
    output logic interlock_out,
    output logic [10:0] heartbeat_id,
    output logic heartbeat_send,
    output logic [10:0] emcy_id,
    output logic emcy_send,
    output logic [3:0] bit_rate_code,
    output logic [9:0] bit_rate_kbps,
    output logic reply_fault,
    output logic stack_init,
    output logic stack_running,
    output logic irq
);
    logic [24:0] div_reg;
    logic tick;
    logic [1:0] ctrl_reg;
    logic [6:0] node_reg;
    logic [2:0] rate_reg;
    logic [7:0] hbeat_reg;
    logic [7:0] reply_reg;
    logic [7:0] emcy_reg;
    logic [6:0] nmt_reg;
    logic [`COS_NEV-1:0] stat_reg;
    logic [`COS_NEV-1:0] mask_reg;
    logic [`COS_NEV-1:0] ev;
    logic start_pulse;
    logic hb_running;
    logic hb_expire;
    logic rp_running;
    logic rp_expire;
    logic em_running;
    logic em_pending_reg;
    logic emcy_fire;
    cos_pkg::cos_stack_t stack_reg;
    logic wr_ctrl;

    // 4 ms tick divider
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= '0;
        end else if (div_reg == 25'(TICK_CYC - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 25'h0000001;
        end
    end
    assign tick = (div_reg == 25'(TICK_CYC - 1));

    // configuration registers
    assign wr_ctrl = bus_req.wr && (bus_req.addr == `COS_ADDR_CTRL);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= 2'h0;
            node_reg <= 7'h00;
            rate_reg <= 3'h0;
            hbeat_reg <= `COS_HBEAT_RST;
            reply_reg <= `COS_REPLY_RST;
            emcy_reg <= `COS_EMCY_RST;
            nmt_reg <= 7'h00;
            mask_reg <= '0;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                `COS_ADDR_CTRL: ctrl_reg <= bus_req.wdata[1:0];
                `COS_ADDR_NODE: node_reg <= bus_req.wdata[6:0];
                `COS_ADDR_RATE: begin
                    // only -3..2 accepted
                    if (bus_req.wdata[2:0] != 3'h4 && bus_req.wdata[2:0] != 3'h3) begin
                        rate_reg <= bus_req.wdata[2:0];
                    end
                end
                `COS_ADDR_HBEAT: hbeat_reg <= bus_req.wdata[7:0];
                `COS_ADDR_REPLY: reply_reg <= bus_req.wdata[7:0];
                `COS_ADDR_EMCY: emcy_reg <= bus_req.wdata[7:0];
                `COS_ADDR_NMT: nmt_reg <= bus_req.wdata[6:0];
                `COS_ADDR_MASK: mask_reg <= bus_req.wdata[`COS_NEV-1:0];
                default: ;
            endcase
        end
    end
    assign start_pulse = bus_req.wr && (bus_req.addr == `COS_ADDR_START) && bus_req.wdata[0];

    // deferred stack start
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stack_reg <= cos_pkg::COS_ST_INIT;
        end else begin
            case (stack_reg)
                cos_pkg::COS_ST_INIT: begin
                    if (ctrl_reg[`COS_CTRL_HOLD] || (wr_ctrl && bus_req.wdata[`COS_CTRL_HOLD])) begin
                        stack_reg <= cos_pkg::COS_ST_HELD;
                    end else begin
                        stack_reg <= cos_pkg::COS_ST_RUN;
                    end
                end
                cos_pkg::COS_ST_HELD: begin
                    if (start_pulse && !ctrl_reg[`COS_CTRL_HOLD]) begin
                        stack_reg <= cos_pkg::COS_ST_RUN;
                    end
                end
                cos_pkg::COS_ST_RUN: stack_reg <= cos_pkg::COS_ST_RUN;
                default: stack_reg <= cos_pkg::COS_ST_HELD;
            endcase
        end
    end
    // one-cycle strobe as the stack leaves init or hold for run
    assign stack_init = ((stack_reg == cos_pkg::COS_ST_INIT) && !ctrl_reg[`COS_CTRL_HOLD]
        && !(wr_ctrl && bus_req.wdata[`COS_CTRL_HOLD]))
        || ((stack_reg == cos_pkg::COS_ST_HELD) && start_pulse
        && !ctrl_reg[`COS_CTRL_HOLD]);
    assign stack_running = (stack_reg == cos_pkg::COS_ST_RUN);

    // heartbeat period
    cos_period_timer #(.W(8)) u_hbeat (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(tick),
        .load(stack_running && !hb_running),
        .stop(!stack_running),
        .period(hbeat_reg),
        .running(hb_running),
        .expire(hb_expire)
    );

    // reply watchdog
    cos_period_timer #(.W(8)) u_reply (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(tick),
        .load(stack_running && link_ev.pdo_sent),
        .stop(link_ev.pdo1_rcvd || link_ev.pdo2_rcvd || reply_reg == 8'h00),
        .period(reply_reg),
        .running(rp_running),
        .expire(rp_expire)
    );

    // emergency spacing
    cos_period_timer #(.W(8)) u_emcy (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(tick),
        .load(emcy_fire),
        .stop(1'b0),
        .period(emcy_reg),
        .running(em_running),
        .expire()
    );
    assign emcy_fire = stack_running && em_pending_reg && !em_running;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            em_pending_reg <= 1'b0;
        end else if (link_ev.emcy_req) begin
            em_pending_reg <= 1'b1;
        end else if (emcy_fire) begin
            em_pending_reg <= 1'b0;
        end
    end

    // outputs
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            heartbeat_send <= 1'b0;
            emcy_send <= 1'b0;
            reply_fault <= 1'b0;
            interlock_out <= 1'b0;
            heartbeat_id <= 11'h000;
            emcy_id <= 11'h000;
        end else begin
            heartbeat_send <= hb_expire;
            emcy_send <= emcy_fire;
            heartbeat_id <= {4'hE, node_reg};
            emcy_id <= {4'h1, node_reg};
            if (reply_reg == 8'h00) begin
                reply_fault <= 1'b0;
            end else if (link_ev.pdo1_rcvd || link_ev.pdo2_rcvd) begin
                reply_fault <= 1'b0;
            end else if (rp_expire) begin
                reply_fault <= 1'b1;
            end
            interlock_out <= interlock_request &&
                (!ctrl_reg[`COS_CTRL_GATE] || nmt_reg == `COS_NMT_OPERATIONAL);
        end
    end

    // bit rate table
    always_comb begin
        bit_rate_code = {1'b0, rate_reg};
        case (rate_reg)
            3'h5: bit_rate_kbps = 10'h014;
            3'h6: bit_rate_kbps = 10'h032;
            3'h7: bit_rate_kbps = 10'h064;
            3'h0: bit_rate_kbps = 10'h07D;
            3'h1: bit_rate_kbps = 10'h0FA;
            3'h2: bit_rate_kbps = 10'h1F4;
            default: bit_rate_kbps = 10'h07D;
        endcase
    end

    // sticky events, write one to clear, set wins
    assign ev[`COS_EV_HBEAT] = hb_expire;
    assign ev[`COS_EV_TMO] = rp_expire && reply_reg != 8'h00
        && !(link_ev.pdo1_rcvd || link_ev.pdo2_rcvd);
    assign ev[`COS_EV_EMCY] = emcy_fire;
    assign ev[`COS_EV_INIT] = (stack_reg == cos_pkg::COS_ST_HELD) && start_pulse
        && !ctrl_reg[`COS_CTRL_HOLD];
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stat_reg <= '0;
        end else if (bus_req.wr && bus_req.addr == `COS_ADDR_IRQ) begin
            stat_reg <= (stat_reg & ~bus_req.wdata[`COS_NEV-1:0]) | ev;
        end else begin
            stat_reg <= stat_reg | ev;
        end
    end
    assign irq = |(stat_reg & mask_reg);

    // read port
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h00000000;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                `COS_ADDR_CTRL: rdata <= {30'h0, ctrl_reg};
                `COS_ADDR_NODE: rdata <= {25'h0, node_reg};
                `COS_ADDR_RATE: rdata <= {{29{rate_reg[2]}}, rate_reg};
                `COS_ADDR_HBEAT: rdata <= {24'h0, hbeat_reg};
                `COS_ADDR_REPLY: rdata <= {24'h0, reply_reg};
                `COS_ADDR_EMCY: rdata <= {24'h0, emcy_reg};
                `COS_ADDR_NMT: rdata <= {25'h0, nmt_reg};
                `COS_ADDR_STAT: rdata <= {27'h0, reply_fault, stack_reg, interlock_out, rp_running} >> 0;
                `COS_ADDR_IRQ: rdata <= {28'h0, stat_reg};
                `COS_ADDR_MASK: rdata <= {28'h0, mask_reg};
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end
endmodule : cos_supervisor
`default_nettype wire

/* test/cos_supervisor_properties.sv */
// port checker for the supervision block
// assumes TICK_CYC matches the bound instance
`timescale 1ns/1ps
`default_nettype none
module cos_supervisor_properties #(
    parameter int TICK_CYC = 10
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire cos_pkg::cos_link_ev_t link_ev,
    input wire logic interlock_request,
    input wire logic interlock_out,
    input wire logic [10:0] heartbeat_id,
    input wire logic heartbeat_send,
    input wire logic [10:0] emcy_id,
    input wire logic emcy_send,
    input wire logic [3:0] bit_rate_code,
    input wire logic [9:0] bit_rate_kbps,
    input wire logic reply_fault,
    input wire logic stack_init,
    input wire logic stack_running
);
    localparam logic [9:0] KB[8] = '{10'h07D, 10'h0FA, 10'h1F4, 10'h000, 10'h000,
        10'h014, 10'h032, 10'h064};
    logic [15:0] hb_gap;
    logic [15:0] em_gap;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // cycles since last heartbeat
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) hb_gap <= 16'hFFFF;
        else if (heartbeat_send) hb_gap <= 16'h0000;
        else if (hb_gap != 16'hFFFF) hb_gap <= hb_gap + 16'h0001;
    end
    // cycles since last emergency message
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) em_gap <= 16'hFFFF;
        else if (emcy_send) em_gap <= 16'h0000;
        else if (em_gap != 16'hFFFF) em_gap <= em_gap + 16'h0001;
    end
    AST_GATE: assert property (interlock_out |-> $past(interlock_request))
        else $error("interlock without request");
    AST_FRAME_ID: assert property ($past(nrst) |-> heartbeat_id[6:0] == emcy_id[6:0])
        else $error("node id differs between frame ids");
    AST_RATE: assert property (!bit_rate_code[3] && bit_rate_kbps == KB[bit_rate_code[2:0]])
        else $error("bit rate mismatch");
    AST_HB_PULSE: assert property (heartbeat_send |=> !heartbeat_send)
        else $error("heartbeat pulse too long");
    AST_HB_GAP: assert property (heartbeat_send |-> hb_gap >= 16'(3 * TICK_CYC - 1))
        else $error("heartbeat too soon");
    AST_HB_RUN: assert property (heartbeat_send |-> $past(stack_running))
        else $error("heartbeat while stack held");
    AST_EM_GAP: assert property (emcy_send |-> em_gap >= 16'(3 * TICK_CYC - 1))
        else $error("emergency spacing broken");
    AST_REPLY_CLR: assert property (link_ev.pdo1_rcvd || link_ev.pdo2_rcvd |=> !reply_fault)
        else $error("reply did not clear fault");
    AST_FAULT_CAUSE: assert property ($rose(reply_fault) |->
        !$past(link_ev.pdo1_rcvd) && !$past(link_ev.pdo2_rcvd))
        else $error("fault despite reply");
    AST_INIT_RUN: assert property (stack_init |=> stack_running)
        else $error("stack start did not take");
    COV_HB: cover property (heartbeat_send);
    COV_FAULT: cover property ($rose(reply_fault));
    COV_EMCY: cover property (emcy_send ##[1:100] emcy_send);
    COV_LOCK: cover property (interlock_out);
endmodule : cos_supervisor_properties
bind cos_supervisor cos_supervisor_properties #(.TICK_CYC(TICK_CYC)) cos_props_i (.*);
`default_nettype wire

/* test/cos_master_model.sv */
// master controller model: answers each slave pdo after a delay
// assumes one-cycle pdo_sent pulses
`timescale 1ns/1ps
`default_nettype none
module cos_master_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic pdo_sent,
    input wire logic answer_en,
    input wire logic use_second,
    input wire logic [7:0] reply_delay,
    output logic pdo1,
    output logic pdo2
);
    logic [7:0] cnt_reg;
    logic busy_reg;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
            cnt_reg <= 8'h00;
            pdo1 <= 1'b0;
            pdo2 <= 1'b0;
        end else begin
            pdo1 <= 1'b0;
            pdo2 <= 1'b0;
            if (pdo_sent && answer_en) begin
                busy_reg <= 1'b1;
                cnt_reg <= reply_delay;
            end else if (busy_reg && cnt_reg == 8'h00) begin
                busy_reg <= 1'b0;
                pdo1 <= !use_second;
                pdo2 <= use_second;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule : cos_master_model
`default_nettype wire

/* test/cos_supervisor_test.sv */
// bench for the supervision block: hold and heartbeat hand tests, rate and node rows, then more hand tests
// assumes model and checker files compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "cos_defines.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR %0t: got %0h want %0h", $time, (a), (b)); end end
module cos_supervisor_test;
    localparam int TC = 10;
    typedef struct {logic [6:0] node; logic [2:0] rate; logic [9:0] kbps;} cos_row_t;
    cos_row_t rows[6] = '{'{7'h00, 3'h5, 10'h014}, '{7'h7F, 3'h6, 10'h032},
        '{7'h55, 3'h7, 10'h064}, '{7'h2A, 3'h0, 10'h07D}, '{7'h01, 3'h1, 10'h0FA},
        '{7'h7E, 3'h2, 10'h1F4}};
    int err_count = 0;
    int n_compared = 0;
    int c;
    logic [31:0] d;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    cos_pkg::cos_bus_req_t bus_req = '0;
    cos_pkg::cos_link_ev_t link_ev;
    logic pdo_sent = 1'b0;
    logic emcy_req = 1'b0;
    logic interlock_request = 1'b1;
    logic answer_en = 1'b1;
    logic use_second = 1'b0;
    logic [7:0] reply_delay = 8'h05;
    logic pdo1, pdo2, interlock_out, heartbeat_send, emcy_send;
    logic reply_fault, stack_init, stack_running, irq;
    logic [31:0] rdata;
    logic [10:0] heartbeat_id, emcy_id;
    logic [3:0] bit_rate_code;
    logic [9:0] bit_rate_kbps;
    assign link_ev = {pdo_sent, pdo1, pdo2, emcy_req};
    cos_supervisor #(.TICK_CYC(TC)) cos_supervisor_i (.*);
    cos_master_model cos_master_model_i (.*);
    always #2.5 ref_clk = ~ref_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        bus_req <= '{a, v, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic pulse(input bit e);
        @(posedge ref_clk);
        if (e) emcy_req <= 1'b1;
        else pdo_sent <= 1'b1;
        @(posedge ref_clk);
        emcy_req <= 1'b0;
        pdo_sent <= 1'b0;
    endtask : pulse
    task automatic wait_for(input int sel, input int lim);
        c = 0;
        do begin
            @(posedge ref_clk);
            #1 c++;
        end while (c < lim && !(sel == 0 ? heartbeat_send : sel == 1 ? emcy_send : reply_fault));
    endtask : wait_for
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    initial begin
        #100000;
        err_count++;
        results();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        bus_req <= '{`COS_ADDR_CTRL, 32'h2, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        rd(`COS_ADDR_HBEAT);
        `CHK(d, 32'hA)
        rd(`COS_ADDR_EMCY);
        `CHK(d, 32'h4)
        rd(8'h3C);
        `CHK(d, 32'h0)
        wr(`COS_ADDR_START, 32'h1);
        cyc(30);
        `CHK(stack_running, 1'b0)
        wr(`COS_ADDR_HBEAT, 32'h4);
        wr(`COS_ADDR_MASK, 32'h8);
        wr(`COS_ADDR_CTRL, 32'h0);
        wr(`COS_ADDR_START, 32'h1);
        cyc(2);
        `CHK({stack_running, irq}, 2'b11)
        wr(`COS_ADDR_IRQ, 32'hF);
        cyc(1);
        `CHK(irq, 1'b0)
        wait_for(0, 100);
        wait_for(0, 100);
        `CHK(c, 4 * TC)
        wr(`COS_ADDR_MASK, 32'h1);
        cyc(1);
        `CHK(irq, 1'b1)
        wr(`COS_ADDR_MASK, 32'h0);
        $display("test hold, heartbeat, irq done");
        foreach (rows[i]) begin
            wr(`COS_ADDR_NODE, {25'h0, rows[i].node});
            wr(`COS_ADDR_RATE, {29'h0, rows[i].rate});
            cyc(2);
            `CHK(bit_rate_kbps, rows[i].kbps)
            `CHK(bit_rate_code, {1'b0, rows[i].rate})
            `CHK(heartbeat_id, {4'hE, rows[i].node})
            `CHK(emcy_id, {4'h1, rows[i].node})
        end
        wr(`COS_ADDR_RATE, 32'h4);
        cyc(2);
        `CHK(bit_rate_kbps, 10'h1F4)
        wr(`COS_ADDR_RATE, 32'h3);
        cyc(2);
        `CHK(bit_rate_kbps, 10'h1F4)
        $display("test rate and node table done");
        wr(`COS_ADDR_CTRL, 32'h1);
        for (int i = 0; i < 8; i++) begin
            wr(`COS_ADDR_NMT, 32'(i));
            cyc(2);
            `CHK(interlock_out, i == 5)
        end
        wr(`COS_ADDR_CTRL, 32'h0);
        cyc(2);
        `CHK(interlock_out, 1'b1)
        interlock_request <= 1'b0;
        cyc(3);
        `CHK(interlock_out, 1'b0)
        interlock_request <= 1'b1;
        $display("test interlock done");
        wr(`COS_ADDR_REPLY, 32'h2);
        for (int i = 0; i < 2; i++) begin
            use_second <= i[0];
            pulse(0);
            cyc(40);
            `CHK(reply_fault, 1'b0)
        end
        answer_en <= 1'b0;
        pulse(0);
        wait_for(2, 40);
        `CHK(c > TC - 3 && c < 2 * TC + 3, 1'b1)
        answer_en <= 1'b1;
        pulse(0);
        cyc(10);
        `CHK(reply_fault, 1'b0)
        wr(`COS_ADDR_REPLY, 32'h0);
        answer_en <= 1'b0;
        pulse(0);
        cyc(60);
        `CHK(reply_fault, 1'b0)
        $display("test reply timeout done");
        pulse(1);
        wait_for(1, 50);
        `CHK(c < 50, 1'b1)
        pulse(1);
        pulse(1);
        wait_for(1, 100);
        `CHK(c > 3 * TC - 5 && c < 100, 1'b1)
        $display("test emergency spacing done");
        results();
    end
endmodule : cos_supervisor_test
`default_nettype wire
